//--- rtl/swrg_pkg.sv
// Constants and types shared by the stop wake-up reset generator.
// Assumes a 40 MHz system clock and an 8-bit register port.
package swrg_pkg;

    // System clock period
    localparam int SYS_CLK_PERIOD_NS = 25;

    // Register offsets, byte addresses
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_STOP   = 4'h8;

    // Control register fields
    localparam int CTRL_CME    = 0;
    localparam int CTRL_SELF_CLOCK_ALLOW   = 1;
    localparam int CTRL_SELF_CLOCK_IRQ_ENABLE  = 2;
    localparam int CTRL_PLL_CLOCK_SELECT = 3;
    localparam int CTRL_OSCILLATOR_KEEP_IN_STOP   = 4;
    localparam int CTRL_RATE_LO = 5;
    localparam logic [7:0] CTRL_RESET = 8'h03;

    // Status register fields
    localparam int STAT_FLAG  = 0;
    localparam int STAT_SCM   = 1;
    localparam int STAT_CMP   = 2;
    localparam int STAT_WDP   = 3;
    localparam int STAT_VEC   = 4;
    localparam int STAT_STOP  = 6;

    // Stop command field
    localparam int STOP_GO = 0;

    // Reset sequence counts in system clock cycles
    localparam int DRIVE_CYCLES  = 128;
    localparam int SYNC_EXTRA    = 3;
    localparam int SETTLE_CYCLES = 64;

    // Clock quality checker
    localparam int OSC_GOOD_CYCLES = 4096;
    localparam int MAX_WINDOWS     = 50;
    localparam int WINDOW_DEFAULT  = 8192;

    // Vector selection codes
    typedef enum logic [1:0] {
        SWRG_VEC_POR = 2'h0,
        SWRG_VEC_CM  = 2'h1,
        SWRG_VEC_WD  = 2'h2
    } swrg_vec_t;

    // Sequencer states
    typedef enum logic [7:0] {
        SWRG_RUN     = 8'h01,
        SWRG_PSTOP   = 8'h02,
        SWRG_FSTOP   = 8'h04,
        SWRG_WAKECHK = 8'h08,
        SWRG_RSTCHK  = 8'h10,
        SWRG_DRIVE   = 8'h20,
        SWRG_SETTLE  = 8'h40,
        SWRG_PINWAIT = 8'h80
    } swrg_state_t;

endpackage

//--- rtl/swrg_cq_if.sv
// Link between the sequencer and its clock quality checker.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface swrg_cq_if;
    logic start;   // Begin a check run
    logic limited; // Stop after the window limit
    logic osc_ok;  // Oscillator seen present
    logic good;    // Pulse, oscillator judged good
    logic failed;  // Pulse, all windows failed
    logic busy;    // A check run is active

    modport judge   (input start, limited, osc_ok, output good, failed, busy);
    modport ctrl    (output start, limited, osc_ok, input good, failed, busy);
endinterface // swrg_cq_if

//--- rtl/swrg_sync3.sv
// Three-stage synchroniser for pins entering the system clock domain.
// Assumes inputs are asynchronous to sys_clk.
`timescale 1ns/1ps
module swrg_sync3 #(
    parameter int       WIDTH = 1,
    parameter bit [7:0] INIT  = 8'h00
) (
    input  wire logic             sys_clk, // System clock
    input  wire logic             resetn,  // Async reset, active low
    input  wire logic [WIDTH-1:0] d,       // Raw pin levels
    output logic      [WIDTH-1:0] q        // Filtered levels
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;

    initial begin
        if (WIDTH < 1 || WIDTH > 8) $error("swrg_sync3: WIDTH out of range");
    end

    // Chain; first stage feeds only the second
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s1 <= INIT[WIDTH-1:0];
            s2 <= INIT[WIDTH-1:0];
            s3 <= INIT[WIDTH-1:0];
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Take a bit once stages two and three agree
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            q <= INIT[WIDTH-1:0];
        end else begin
            q <= (s2 & s3) | (q & (s2 ^ s3));
        end
    end
endmodule // swrg_sync3

//--- rtl/swrg_quality_checker.sv
// Clock quality checker: counts check windows until the oscillator is steady.
// Assumes osc_ok is already synchronised to sys_clk.
`timescale 1ns/1ps
module swrg_quality_checker
    import swrg_pkg::*;
#(
    parameter int WINDOW_CYCLES = WINDOW_DEFAULT
) (
    input  wire logic  sys_clk, // System clock
    input  wire logic  resetn,  // Async reset, active low
    swrg_cq_if.judge   cq       // Sequencer side
);
    logic [15:0] win_cnt;
    logic [12:0] ok_cnt;
    logic [5:0]  win_num;
    logic        ok_done;

    initial begin
        if (WINDOW_CYCLES <= OSC_GOOD_CYCLES || WINDOW_CYCLES > 65535)
            $error("swrg_quality_checker: WINDOW_CYCLES out of range");
    end

    assign ok_done = cq.osc_ok && (ok_cnt == 13'(OSC_GOOD_CYCLES - 1));

    // Window and steadiness counters
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cq.busy   <= 1'b0;
            cq.good   <= 1'b0;
            cq.failed <= 1'b0;
            win_cnt   <= 16'h0000;
            ok_cnt    <= 13'h0000;
            win_num   <= 6'h00;
        end else begin
            cq.good   <= 1'b0;
            cq.failed <= 1'b0;
            if (cq.start) begin
                cq.busy <= 1'b1;
                win_cnt <= 16'h0000;
                ok_cnt  <= 13'h0000;
                win_num <= 6'h00;
            end else if (cq.busy) begin
                ok_cnt <= cq.osc_ok ? ok_cnt + 13'h0001 : 13'h0000;
                if (ok_done) begin
                    cq.good <= 1'b1;
                    cq.busy <= 1'b0;
                end else if (win_cnt == 16'(WINDOW_CYCLES - 1)) begin
                    win_cnt <= 16'h0000;
                    win_num <= win_num + 6'h01;
                    // Limited runs give up; others repeat without end
                    if (cq.limited && win_num == 6'(MAX_WINDOWS - 1)) begin // RULE4
                        cq.failed <= 1'b1;
                        cq.busy   <= 1'b0;
                    end
                end else begin
                    win_cnt <= win_cnt + 16'h0001;
                end
            end
        end
    end
endmodule // swrg_quality_checker

//--- rtl/swrg_top.sv
// Stop-mode wake-up sequencer and reset generator with vector selection.
// Assumes a running sys_clk for sequencing, an open-drain reset pin with a
// pull-up, and a clock monitor that reports oscillator loss and presence.
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// RULE1 - Pseudo-stop clock loss with self-clock allowed: power up, self-clock, check, flag
// RULE2 - Oscillator good again in pseudo-stop: leave self-clock, power down, stay stopped
// RULE3 - After recovery, wake resumes on oscillator; external reset starts sequence
// RULE4 - Without recovery, quality checks repeat endlessly during pseudo-stop
// RULE5 - Without recovery, wake or reset leaves stop in self-clock, checks continue
// RULE6 - With interrupt enabled, the raised flag itself wakes from pseudo-stop
// RULE7 - Only an external interrupt or reset wakes from full stop
// RULE8 - Reset in full stop: restore defaults, check up to 50 windows, then sequence
// RULE9 - Interrupt wake from full stop: check; on failure self-clock or monitor reset
// RULE10 - Leaving any stop clears the synth clock select bit
// RULE11 - Clock monitor ignored during full stop
// RULE12 - Reset sources: pin low, power-on, low voltage, watchdog, monitor failure
// RULE13 - Drive reset pin low for 128 plus synchronisation cycles, then release
// RULE14 - Reset entry is asynchronous; leaving reset needs the running clock
// RULE15 - Sample the pin 64 cycles after release to find the origin
// RULE16 - Vector: monitor, watchdog or power-on by pending flags and pin level
// RULE17 - Internal reset held through the sequence and while the pin stays low
// RULE18 - Monitor reset forces enables on, enters self-clock, checks in parallel
// RULE19 - Power-on or low voltage: check clock first, else sequence in self-clock
// RULE20 - Pin load must let the pin rise within 64 cycles of release
// RULE21 - Sense the pin through a synchroniser before using it
// RULE22 - Latch monitor and watchdog causes until the vector is chosen
module swrg_top
    import swrg_pkg::*;
#(
    parameter int WINDOW_CYCLES = WINDOW_DEFAULT
) (
    input  wire logic       sys_clk,          // System clock, 40 MHz
    input  wire logic       resetn,           // Power-on reset, active low
    input  wire logic       low_voltage,      // Low voltage detected
    input  wire logic       watchdog_timeout, // Watchdog expiry pulse
    input  wire logic       wake_irq,         // External or periodic wake-up
    input  wire logic       osc_lost_in,      // Clock monitor: oscillator lost
    input  wire logic       osc_ok_in,        // Oscillator present
    input  wire logic       reset_pin_in,     // Reset pin level
    output logic            reset_pin_out,    // Reset pin drive value
    output logic            reset_pin_oe,     // Reset pin drive enable
    input  wire logic [3:0] reg_addr,         // Register address
    input  wire logic [7:0] reg_wdata,        // Write data
    input  wire logic       reg_wr,           // Write strobe
    input  wire logic       reg_rd,           // Read strobe
    output logic      [7:0] reg_rdata,        // Read data, next cycle
    output logic            internal_reset_n, // Core reset, active low
    output logic            self_clock_mode,  // Running on fallback clock
    output logic            regulator_enable, // Voltage regulator on
    output logic            synth_enable,     // Frequency synthesiser on
    output logic            pll_clock_select, // System clock from synthesiser
    output logic            stop_active,      // In a stop mode
    output logic      [1:0] vector_sel,       // Chosen reset vector
    output logic            vector_fetch      // Pulse, vector chosen
);
    swrg_cq_if cq ();

    swrg_state_t state;
    swrg_state_t next_state;
    logic [7:0]  ctrl;
    logic        scm_flag;
    logic        cm_pend;
    logic        wd_pend;
    logic [7:0]  cnt;
    logic [2:0]  pins_s;
    logic        pin_high;
    logic        lost;
    logic        ext_rst;
    logic        wd_rst;
    logic        loss;
    logic        seq_go;
    logic        cm_go;
    logic        scm_enter;
    logic        scm_leave;
    logic        cq_go;
    logic        cq_lim;
    logic        exit_stop;
    logic        vec_go;
    logic        stop_req;
    logic        in_stop;
    logic        in_reset;
    logic        por_kick;
    logic        next_scm;

    initial begin
        if (WINDOW_CYCLES <= OSC_GOOD_CYCLES)
            $error("swrg_top: WINDOW_CYCLES too short");
    end

    // Pin and clock monitor inputs into the clock domain
    swrg_sync3 #(
        .WIDTH (3),
        .INIT  (8'h05)
    ) u_sync (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .d       ({osc_ok_in, osc_lost_in, reset_pin_in}),
        .q       (pins_s)
    ); // RULE21

    swrg_quality_checker #(
        .WINDOW_CYCLES (WINDOW_CYCLES)
    ) u_cq (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .cq      (cq.judge)
    );

    assign pin_high  = pins_s[0];
    assign lost      = pins_s[1];
    assign cq.osc_ok = pins_s[2];
    assign cq.start   = cq_go;
    assign cq.limited = cq_lim;
    assign next_scm   = scm_enter || (self_clock_mode && !scm_leave); // Self-clock level after this edge

    // Event decode
    assign in_stop  = (state == SWRG_PSTOP) || (state == SWRG_FSTOP);
    assign in_reset = (state == SWRG_DRIVE) || (state == SWRG_SETTLE) ||
                      (state == SWRG_PINWAIT) || (state == SWRG_RSTCHK);
    assign ext_rst  = ~pin_high;
    assign wd_rst   = watchdog_timeout && (ctrl[CTRL_RATE_LO +: 3] != 3'h0); // RULE12
    assign loss     = lost && ctrl[CTRL_CME] &&
                      ((state == SWRG_RUN) || (state == SWRG_PSTOP)); // RULE11
    assign stop_req = reg_wr && (reg_addr == ADDR_STOP) && reg_wdata[STOP_GO];

    // Next state and sequencing events
    always_comb begin
        next_state = state;
        seq_go     = 1'b0;
        cm_go      = 1'b0;
        scm_enter  = 1'b0;
        scm_leave  = 1'b0;
        cq_go      = 1'b0;
        cq_lim     = 1'b0;
        exit_stop  = 1'b0;
        vec_go     = 1'b0;
        unique case (state)
            SWRG_RUN: begin
                if (stop_req) begin
                    next_state = ctrl[CTRL_OSCILLATOR_KEEP_IN_STOP] ? SWRG_PSTOP : SWRG_FSTOP;
                end
            end
            SWRG_PSTOP: begin
                // Plain wake or flag wake with interrupt enabled
                if (wake_irq || (scm_flag && ctrl[CTRL_SELF_CLOCK_IRQ_ENABLE])) begin // RULE3 RULE5 RULE6
                    next_state = SWRG_RUN;
                    exit_stop  = 1'b1;
                end
            end
            SWRG_FSTOP: begin
                if (ext_rst) begin // RULE7 RULE8
                    next_state = SWRG_RSTCHK;
                    seq_go     = 1'b1;
                    cq_go      = 1'b1;
                    cq_lim     = 1'b1;
                    exit_stop  = 1'b1;
                end else if (wake_irq) begin // RULE7 RULE9
                    next_state = SWRG_WAKECHK;
                    cq_go      = 1'b1;
                    cq_lim     = 1'b1;
                    exit_stop  = 1'b1;
                end
            end
            SWRG_WAKECHK: begin
                if (cq.good) begin // RULE9
                    next_state = SWRG_RUN;
                end else if (cq.failed) begin
                    if (ctrl[CTRL_SELF_CLOCK_ALLOW]) begin
                        next_state = SWRG_RUN;
                        scm_enter  = 1'b1;
                        cq_go      = 1'b1;
                    end else begin
                        next_state = SWRG_DRIVE;
                        seq_go     = 1'b1;
                        cm_go      = 1'b1;
                    end
                end
            end
            SWRG_RSTCHK: begin
                if (cq.good) begin // RULE8 RULE19
                    next_state = SWRG_DRIVE;
                end else if (cq.failed) begin
                    next_state = SWRG_DRIVE;
                    scm_enter  = 1'b1;
                    cq_go      = 1'b1;
                end
            end
            SWRG_DRIVE: begin
                if (cnt == 8'(DRIVE_CYCLES + SYNC_EXTRA - 1)) begin // RULE13
                    next_state = SWRG_SETTLE;
                end
            end
            SWRG_SETTLE: begin
                if (cnt == 8'(SETTLE_CYCLES - 1)) begin // RULE15
                    if (pin_high) begin
                        next_state = SWRG_RUN;
                        vec_go     = 1'b1;
                    end else begin
                        next_state = SWRG_PINWAIT;
                    end
                end
            end
            SWRG_PINWAIT: begin
                if (pin_high) begin // RULE16 RULE17
                    next_state = SWRG_RUN;
                    vec_go     = 1'b1;
                end
            end
        endcase

        // Clock loss while the monitor watches
        if (loss && !self_clock_mode && (next_state == state)) begin
            if (!ctrl[CTRL_SELF_CLOCK_ALLOW]) begin
                next_state = SWRG_DRIVE; // RULE12
                seq_go     = 1'b1;
                cm_go      = 1'b1;
                exit_stop  = in_stop;
            end else begin
                scm_enter = 1'b1; // RULE1 RULE6
                cq_go     = 1'b1;
            end
        end
        // Monitor reset enters self-clock with checks in parallel
        if (cm_go && !self_clock_mode) begin
            scm_enter = 1'b1; // RULE18
            cq_go     = 1'b1;
        end
        // Oscillator judged good while in self-clock
        if (self_clock_mode && cq.good && !cq_go) begin
            scm_leave = 1'b1; // RULE2 RULE18
        end
        // Pin low or watchdog while running or in pseudo-stop
        if (!in_reset && (state != SWRG_FSTOP) && (state != SWRG_WAKECHK) &&
            (ext_rst || wd_rst)) begin
            next_state = SWRG_DRIVE; // RULE3 RULE5 RULE12
            seq_go     = 1'b1;
            exit_stop  = in_stop;
        end
        // First check run right after power-on release
        if (por_kick) begin
            cq_go  = 1'b1; // RULE19
            cq_lim = 1'b1;
        end
        // Low voltage restarts from a clock check
        if (low_voltage) begin
            next_state = SWRG_RSTCHK; // RULE19
            seq_go     = 1'b1;
            cq_go      = 1'b1;
            cq_lim     = 1'b1;
            exit_stop  = in_stop;
        end
    end

    // Sequencer state; power-on enters the clock check at once
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state <= SWRG_RSTCHK; // RULE14 RULE19
        end else begin
            state <= next_state;
        end
    end

    // Power-on starts the first check run right after release
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            por_kick <= 1'b1;
        end else begin
            por_kick <= 1'b0;
        end
    end

    // Phase counter for drive and settle
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 8'h00;
        end else if (next_state != state) begin
            cnt <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end

    // Control register; any reset event restores defaults
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl <= CTRL_RESET; // RULE14
        end else if (seq_go) begin
            ctrl <= CTRL_RESET; // RULE8 RULE18
        end else begin
            if (reg_wr && (reg_addr == ADDR_CTRL) && !in_reset) begin
                ctrl <= reg_wdata;
            end
            if (exit_stop) begin
                ctrl[CTRL_PLL_CLOCK_SELECT] <= 1'b0; // RULE10
            end
        end
    end

    // Self-clock mode and its change flag; a change beats the clear
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            self_clock_mode <= 1'b0;
            scm_flag        <= 1'b0;
        end else begin
            if (scm_enter) begin
                self_clock_mode <= 1'b1; // RULE1 RULE5
            end else if (scm_leave) begin
                self_clock_mode <= 1'b0; // RULE2
            end
            if (scm_enter || scm_leave) begin
                scm_flag <= 1'b1; // RULE1
            end else if (reg_wr && (reg_addr == ADDR_STATUS) && reg_wdata[STAT_FLAG]) begin
                scm_flag <= 1'b0;
            end
        end
    end

    // Pending causes, held until the vector is chosen
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cm_pend <= 1'b0;
            wd_pend <= 1'b0;
        end else begin
            if (cm_go) begin
                cm_pend <= 1'b1; // RULE22
            end else if (vec_go) begin
                cm_pend <= 1'b0;
            end
            if (wd_rst) begin
                wd_pend <= 1'b1; // RULE22
            end else if (vec_go) begin
                wd_pend <= 1'b0;
            end
        end
    end

    // Vector choice from sampled pin and pending causes
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            vector_sel   <= SWRG_VEC_POR;
            vector_fetch <= 1'b0;
        end else begin
            vector_fetch <= vec_go;
            if (vec_go) begin
                if (state == SWRG_PINWAIT) begin
                    vector_sel <= SWRG_VEC_POR; // RULE16
                end else if (cm_pend) begin
                    vector_sel <= SWRG_VEC_CM; // RULE16
                end else if (wd_pend) begin
                    vector_sel <= SWRG_VEC_WD;
                end else begin
                    vector_sel <= SWRG_VEC_POR;
                end
            end
        end
    end

    // Pin drive, internal reset and power controls
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reset_pin_oe     <= 1'b0;
            internal_reset_n <= 1'b0; // RULE14
            regulator_enable <= 1'b1;
            synth_enable     <= 1'b0;
            stop_active      <= 1'b0;
        end else begin
            reset_pin_oe     <= (next_state == SWRG_DRIVE); // RULE13
            internal_reset_n <= (next_state != SWRG_DRIVE) && (next_state != SWRG_SETTLE) &&
                                (next_state != SWRG_PINWAIT) && (next_state != SWRG_RSTCHK); // RULE17
            stop_active      <= (next_state == SWRG_PSTOP) || (next_state == SWRG_FSTOP);
            // In stop the regulator and synthesiser follow self-clock mode, in step with it
            regulator_enable <= !((next_state == SWRG_PSTOP) || (next_state == SWRG_FSTOP)) || next_scm; // RULE1 RULE2
            synth_enable     <= next_scm || (!((next_state == SWRG_PSTOP) || (next_state == SWRG_FSTOP)) &&
                                ctrl[CTRL_PLL_CLOCK_SELECT]);
        end
    end

    assign reset_pin_out    = 1'b0;
    assign pll_clock_select = ctrl[CTRL_PLL_CLOCK_SELECT];

    // Register read port, data one cycle after the strobe
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ADDR_CTRL:   reg_rdata <= ctrl;
                ADDR_STATUS: reg_rdata <= {1'b0, stop_active, vector_sel, wd_pend, cm_pend,
                                           self_clock_mode, scm_flag};
                default:     reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule // swrg_top

//--- verification/swrg_sva.sv
// Checker on top ports: pin drive, vector strobe, stop exit.
// Assumes it is bound to swrg_top.
`timescale 1ns/1ps
module swrg_sva #(parameter int WINDOW_CYCLES = 8192) (
    input wire logic sys_clk, // Clock
    input wire logic resetn, // Reset
    input wire logic reset_pin_in, // Pin level
    input wire logic reset_pin_out, // Drive value
    input wire logic reset_pin_oe, // Drive enable
    input wire logic internal_reset_n, // Core reset
    input wire logic vector_fetch, // Vector strobe
    input wire logic self_clock_mode, // Fallback
    input wire logic synth_enable, // Synth on
    input wire logic pll_clock_select, // Synth select
    input wire logic stop_active // Stopped
);
    logic [7:0] oe_cycles;
    // Cycles of pin drive
    always_ff @(posedge sys_clk or negedge resetn)
        if (!resetn) oe_cycles <= 8'h00;
        else oe_cycles <= reset_pin_oe ? oe_cycles + 8'h01 : 8'h00;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // Pin let go with nothing holding it low
    sequence s_released;
        $fell(reset_pin_oe) && reset_pin_in;
    endsequence
    a_drive_length: assert property ($fell(reset_pin_oe) |-> oe_cycles == 8'h83) else $error("drive length");
    a_settle_wait: assert property (s_released |-> ##1 !vector_fetch [*8] ##56 vector_fetch) else $error("settle");
    a_drive_low: assert property (reset_pin_oe |-> !reset_pin_out) else $error("pin value");
    a_core_held: assert property (reset_pin_oe |-> !internal_reset_n) else $error("core free");
    a_release_fetch: assert property ($rose(internal_reset_n) |-> vector_fetch) else $error("release");
    a_fetch_pulse: assert property (vector_fetch |=> !vector_fetch) else $error("fetch width");
    a_stop_pll: assert property ($fell(stop_active) |-> ##[0:2] !pll_clock_select) else $error("select");
    a_fallback_on: assert property (self_clock_mode |-> synth_enable) else $error("synth off");
endmodule // swrg_sva
bind swrg_top swrg_sva #(.WINDOW_CYCLES(WINDOW_CYCLES)) u_sva (.*);

//--- verification/swrg_pin_model.sv
// Outside reset circuit: pull-up and an optional holder.
// Assumes an open-drain device pin.
`timescale 1ns/1ps
module swrg_pin_model (
    input wire logic reset_pin_out, // Drive value
    input wire logic reset_pin_oe, // Drive enable
    input wire logic hold_low, // Outside reset
    output logic reset_pin_in // Pin level
);
    // Light pull-up lifts the pin at once
    assign reset_pin_in = (reset_pin_oe && !reset_pin_out) || hold_low ? 1'h0 : 1'h1;
endmodule // swrg_pin_model

//--- verification/swrg_top_tb.sv
// Bench: reset vectors, control reset value, stop entry and exit.
// Assumes the pin model and a short check window.
`timescale 1ns/1ps
module swrg_top_tb;
    import swrg_pkg::*;
    logic sys_clk = 0, resetn = 0, low_voltage = 0, watchdog_timeout = 0, wake_irq = 0, osc_lost_in = 0;
    logic hold_low = 0, osc_ok_in = 1, reg_wr = 0, reg_rd = 0, reset_pin_in, reset_pin_out, reset_pin_oe;
    logic internal_reset_n, self_clock_mode, regulator_enable, synth_enable, pll_clock_select, stop_active;
    logic vector_fetch;
    logic [1:0] vector_sel;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    int failures = 0, comparisons = 0, cycles = 0;
    swrg_top #(.WINDOW_CYCLES(4200)) uut (.*);
    swrg_pin_model u_pin (.*);
    initial forever #12.5 sys_clk = ~sys_clk;
    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            results();
        end
    end
    task results();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(string n, logic [7:0] e, logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task tick(int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task wr(logic [3:0] a, logic [7:0] d);
        tick(1);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        tick(1);
        reg_wr <= 1'h0;
    endtask
    // Bounded wait for the vector strobe
    task fetch(logic [1:0] v);
        repeat (9000) if (vector_fetch !== 1'h1) @(negedge sys_clk);
        chk("vector", {5'h01, v}, {5'h00, internal_reset_n, vector_sel});
        tick(1);
    endtask
    task stops(logic [7:0] e);
        chk("stop outputs", e, {3'h0, regulator_enable, stop_active, self_clock_mode, synth_enable, reset_pin_oe});
    endtask
    // Main sequence
    initial begin
        tick(10);
        resetn <= 1'h1;
        tick(1);
        low_voltage <= 1'h1;
        tick(1);
        low_voltage <= 1'h0;
        fetch(SWRG_VEC_POR);
        wr(4'hc, 8'hff);
        reg_addr <= ADDR_CTRL;
        tick(1);
        reg_rd <= 1'h1;
        tick(1);
        reg_rd <= 1'h0;
        @(negedge sys_clk);
        chk("ctrl", CTRL_RESET, reg_rdata);
        wr(ADDR_CTRL, 8'h22);
        watchdog_timeout <= 1'h1;
        tick(1);
        watchdog_timeout <= 1'h0;
        fetch(SWRG_VEC_WD);
        wr(ADDR_CTRL, 8'h01);
        osc_lost_in <= 1'h1;
        tick(6);
        osc_lost_in <= 1'h0;
        fetch(SWRG_VEC_CM);
        hold_low <= 1'h1;
        tick(400);
        chk("held", 8'h00, {7'h00, internal_reset_n});
        hold_low <= 1'h0;
        fetch(SWRG_VEC_POR);
        repeat (4200) if (self_clock_mode !== 1'h0) tick(1);
        chk("fallback left", 8'h00, {7'h00, self_clock_mode});
        // Pseudo-stop loss, recovery, wake
        wr(ADDR_CTRL, 8'h13);
        wr(ADDR_STOP, 8'h01);
        osc_lost_in <= 1'h1;
        osc_ok_in <= 1'h0;
        tick(20);
        stops(8'h1e);
        osc_lost_in <= 1'h0;
        osc_ok_in <= 1'h1;
        tick(4500);
        stops(8'h08);
        wake_irq <= 1'h1;
        tick(1);
        wake_irq <= 1'h0;
        tick(10);
        stops(8'h10);
        // Full stop ignores loss
        wr(ADDR_CTRL, 8'h0b);
        wr(ADDR_STOP, 8'h01);
        osc_lost_in <= 1'h1;
        tick(20);
        stops(8'h08);
        osc_lost_in <= 1'h0;
        wake_irq <= 1'h1;
        tick(1);
        wake_irq <= 1'h0;
        repeat (9000) if (stop_active !== 1'h0) tick(1);
        chk("select", 8'h00, {6'h00, stop_active, pll_clock_select});
        results();
    end
endmodule // swrg_top_tb
